//--- host_plc_model.sv
/*
  Host controller model: drives the discrete input pins of the pattern select block.
  Assumes the bench hands it a pin pattern with a one-cycle go pulse on clk_sys.
*/
`timescale 1ns/100ps
module host_plc_model #(
  parameter int HOLD_CYC = 150000
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [15:0] pinReq,
  input wire logic go,
  output logic [15:0] pioIn,
  output logic busy
);
  typedef struct packed {
    logic [15:0] pins;
    logic [17:0] cnt;
    logic busy;
  } plc_t;
  plc_t st_reg;
  plc_t st_next;
  always_comb begin
    st_next = st_reg;
    if (go) begin
      // Start (pin 6) drops first so that each request with start set gives the device a fresh rising edge; the map 5 inputs, pins 3 to 0, do not drop.
      st_next.pins = pinReq & 16'hffbf;
      st_next.cnt = 18'(HOLD_CYC);
      st_next.busy = 1'b1;
    end else if (st_reg.busy && st_reg.cnt != 18'h00000) begin
      st_next.cnt = st_reg.cnt - 18'h00001;
    end else if (st_reg.busy) begin
      st_next.pins[6] = pinReq[6];
      st_next.busy = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign pioIn = st_reg.pins;
  assign busy = st_reg.busy;
endmodule : host_plc_model

//--- parallel_io_pattern_select.sv
/*
  Parallel I/O pattern select: maps the host pins onto motion core controls and
  the core status onto the host pins, for one of six maps, with an AXI4-Lite
  register slave. Assumes a motion core on clk_sys and asynchronous host pins.
*/
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "pio_sel_defs.svh"
module parallel_io_pattern_select
  import pio_sel_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [`PIN_W-1:0] pioIn,
  output logic [`PIN_W-1:0] pioOut,
  input wire logic [`LIM_W-1:0] curPos,
  input wire logic [`POS_W-1:0] donePos,
  input wire logic posEnd,
  input wire logic homeEnd,
  input wire logic zone1In,
  input wire logic moving,
  input wire logic ready,
  input wire logic alarmN,
  output logic [`POS_W-1:0] cmdPos,
  output logic cmdStart,
  output logic pauseN,
  output logic homeReq,
  output logic servoOn,
  output logic alarmRst,
  output logic jogFwd,
  output logic jogRev,
  output logic writeReq,
  output logic teachMode
);
  state_t state_reg;
  state_t state_next;
  logic [`PIN_W-1:0] pinIn;
  logic hasHome;
  logic hasServo;
  logic hasReset;
  logic hasJog;
  logic hasMove;
  logic hasReady;
  logic hasZone1;
  logic hasZone2;
  logic zone2Hit;
  logic [`POS_W-1:0] posNext;
  logic startNext;

  pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pinRaw(pioIn),
    .pinClean(pinIn)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  function automatic logic known(input logic [7:0] a);
    return a == `REG_MAP || a == `REG_ZLO || a == `REG_ZHI || a == `REG_SVDIS
        || a == `REG_CTRL || a == `REG_STAT;
  endfunction : known

  assign awready = !state_reg.awHave;
  assign wready = !state_reg.wHave;
  assign arready = !state_reg.rValid;
  assign bvalid = state_reg.bValid;
  assign bresp = state_reg.bResp;
  assign rvalid = state_reg.rValid;
  assign rdata = state_reg.rData;
  assign rresp = state_reg.rResp;
  assign zone2Hit = homeEnd && curPos >= state_reg.zoneLo && curPos <= state_reg.zoneHi;

  // Which functions exist in the active map.
  always_comb begin
    hasHome = 1'b0;
    hasServo = 1'b0;
    hasReset = 1'b1;
    hasJog = 1'b0;
    hasMove = 1'b0;
    hasReady = 1'b0;
    hasZone1 = 1'b0;
    hasZone2 = 1'b0;
    unique case (state_reg.mapAct)
      MAP_LEGACY: begin
        hasReset = 1'b0; // RULE2
        hasZone1 = 1'b1; // RULE2
      end
      MAP_STD: begin
        {hasHome, hasServo, hasMove, hasReady, hasZone1} = 5'h1f; // RULE3
      end
      MAP_POS64: begin
        {hasHome, hasMove} = 2'h3; // RULE4
      end
      MAP_ZONE2: begin
        {hasHome, hasServo, hasReady, hasZone1, hasZone2} = 5'h1f; // RULE5
      end
      MAP_TEACH: begin
        {hasHome, hasServo, hasJog, hasMove, hasReady} = 5'h1f; // RULE10
      end
      MAP_AIR: begin
        hasZone1 = 1'b1; // RULE11
      end
      default: begin
        hasReset = 1'b0;
      end
    endcase
  end

  // Position number and start from the pins; map 5 turns direct inputs into both.
  always_comb begin
    posNext = '0;
    startNext = pinIn[`IN_START];
    unique case (state_reg.mapAct)
      MAP_POS64: begin
        posNext = pinIn[`POS_W-1:0]; // RULE4
      end
      MAP_AIR: begin
        startNext = |pinIn[3:0]; // RULE11
        for (int k = 3; k >= 0; k--) begin
          if (pinIn[k]) begin
            posNext = `POS_W'(k);
          end
        end
      end
      default: begin
        posNext = {2'h0, pinIn[3:0]};
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    if (awvalid && !state_reg.awHave) begin
      state_next.awHave = 1'b1;
      state_next.awAddr = awaddr[7:0];
    end
    if (wvalid && !state_reg.wHave) begin
      state_next.wHave = 1'b1;
      state_next.wData = wdata;
      state_next.wStrb = wstrb;
    end
    if (state_reg.bValid && bready) begin
      state_next.bValid = 1'b0;
    end
    if (state_reg.awHave && state_reg.wHave && !state_reg.bValid) begin
      state_next.awHave = 1'b0;
      state_next.wHave = 1'b0;
      state_next.bValid = 1'b1;
      state_next.bResp = known(state_reg.awAddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (state_reg.awAddr)
        `REG_MAP: state_next.mapStore = 3'(merge(32'(state_reg.mapStore), state_reg.wData,
                                                 state_reg.wStrb)); // RULE1
        `REG_ZLO: state_next.zoneLo = `LIM_W'(merge(32'(state_reg.zoneLo), state_reg.wData,
                                                    state_reg.wStrb)); // RULE6
        `REG_ZHI: state_next.zoneHi = `LIM_W'(merge(32'(state_reg.zoneHi), state_reg.wData,
                                                    state_reg.wStrb)); // RULE6
        `REG_SVDIS: begin
          if (state_reg.wStrb[0]) begin
            state_next.servoDis = state_reg.wData[0];
          end
        end
        `REG_CTRL: begin
          // Reload stands in for a restart; the map is switched whether or not a move is running.
          if (state_reg.wStrb[0] && state_reg.wData[0] && state_reg.mapStore <= `MAP_MAX) begin
            state_next.mapAct = map_t'(state_reg.mapStore); // RULE14
          end
        end
        default: begin
        end
      endcase
    end
    if (arvalid && !state_reg.rValid) begin
      state_next.rValid = 1'b1;
      state_next.rResp = known(araddr[7:0]) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (araddr[7:0])
        `REG_MAP: state_next.rData = 32'(state_reg.mapStore);
        `REG_ZLO: state_next.rData = 32'(state_reg.zoneLo);
        `REG_ZHI: state_next.rData = 32'(state_reg.zoneHi);
        `REG_SVDIS: state_next.rData = 32'(state_reg.servoDis);
        `REG_STAT: state_next.rData = {27'h0, state_reg.teach, state_reg.mapAct, 1'b0};
        default: state_next.rData = 32'h0;
      endcase
    end else if (state_reg.rValid && rready) begin
      state_next.rValid = 1'b0;
    end

    // Mode change is taken only while stopped, so the mode pin never switches mode midway; leaving map 4 clears teach even during a move.
    if (state_reg.mapAct != MAP_TEACH) begin
      state_next.teach = 1'b0;
    end else if (pinIn[`IN_MODE] != state_reg.teach && !moving) begin
      state_next.teach = pinIn[`IN_MODE]; // RULE8
    end

    state_next.cmdPos = posNext;
    state_next.ctl = {
      startNext,
      pinIn[`IN_PAUSE],
      hasHome && pinIn[`IN_HOME],
      hasServo ? pinIn[`IN_SERVO] : state_reg.servoDis, // RULE12
      hasReset && pinIn[`IN_RESET],
      hasJog && state_reg.teach && pinIn[`IN_JOGF], // RULE7
      hasJog && state_reg.teach && pinIn[`IN_JOGR], // RULE7
      hasJog && state_reg.teach && pinIn[`IN_WRITE], // RULE7
      state_reg.teach,
      1'b0
    };

    state_next.pioOut = '0;
    if (state_reg.mapAct == MAP_AIR) begin
      for (int k = 0; k < 4; k++) begin
        state_next.pioOut[k] = posEnd && donePos == `POS_W'(k); // RULE11
      end
    end else begin
      state_next.pioOut[`POS_W-1:0] = donePos;
    end
    state_next.pioOut[`OUT_PEND] = posEnd;
    state_next.pioOut[`OUT_HEND] = homeEnd;
    state_next.pioOut[`OUT_ZONE1] = hasZone1 && zone1In;
    state_next.pioOut[`OUT_ZONE2] = hasZone2 && zone2Hit; // RULE6
    state_next.pioOut[`OUT_MOVE] = hasMove && moving;
    state_next.pioOut[`OUT_READY] = hasReady && ready;
    state_next.pioOut[`OUT_ALARM] = alarmN;
    state_next.pioOut[`OUT_MDONE] = state_reg.mapAct == MAP_TEACH
                                    && state_reg.teach == pinIn[`IN_MODE]; // RULE9
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pioOut = state_reg.pioOut;
  assign cmdPos = state_reg.cmdPos;
  assign {cmdStart, pauseN, homeReq, servoOn, alarmRst} = state_reg.ctl[9:5];
  assign {jogFwd, jogRev, writeReq, teachMode} = state_reg.ctl[4:1];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_mapRange;
    state_reg.mapAct <= `MAP_MAX;
  endproperty
  a_mapRange: assert property (p_mapRange) else $error("active map out of range"); // RULE1

  property p_reserved;
    state_reg.awHave && state_reg.wHave && !state_reg.bValid && state_reg.awAddr == `REG_CTRL
      && state_reg.mapStore > `MAP_MAX |=> $stable(state_reg.mapAct);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved map applied"); // RULE14

  property p_legacy;
    state_reg.mapAct == MAP_LEGACY |=> !homeReq && !alarmRst && !jogFwd && !pioOut[`OUT_MOVE];
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy map drives absent function"); // RULE2

  property p_stdZone;
    state_reg.mapAct == MAP_STD && $stable(state_reg.mapAct)
      |-> pioOut[`OUT_ZONE1] == $past(zone1In) && pioOut[`OUT_MOVE] == $past(moving);
  endproperty
  a_stdZone: assert property (p_stdZone) else $error("standard map zone or moving wrong"); // RULE3

  property p_pos64;
    state_reg.mapAct == MAP_POS64 && $stable(state_reg.mapAct)
      |-> cmdPos == $past(pinIn[`POS_W-1:0]) && !pioOut[`OUT_ZONE1] && !pioOut[`OUT_READY];
  endproperty
  a_pos64: assert property (p_pos64) else $error("64-point map decode wrong"); // RULE4

  property p_zone2;
    state_reg.mapAct == MAP_ZONE2 && zone2Hit |=> pioOut[`OUT_ZONE2] && !pioOut[`OUT_MOVE];
  endproperty
  a_zone2: assert property (p_zone2) else $error("second zone not driven"); // RULE5

  sequence s_modeAsk;
    state_reg.mapAct == MAP_TEACH && pinIn[`IN_MODE] != state_reg.teach && !moving;
  endsequence
  sequence s_modeDone;
    ##1 state_reg.teach == $past(pinIn[`IN_MODE]) ##1 state_reg.mapAct != MAP_TEACH
      || pioOut[`OUT_MDONE] == (state_reg.teach == $past(pinIn[`IN_MODE]));
  endsequence
  property p_modeDone;
    s_modeAsk |-> s_modeDone;
  endproperty
  a_modeDone: assert property (p_modeDone) else $error("mode change not confirmed"); // RULE9

  property p_teachNoZone;
    state_reg.mapAct == MAP_TEACH |=> !pioOut[`OUT_ZONE1] && !pioOut[`OUT_ZONE2];
  endproperty
  a_teachNoZone: assert property (p_teachNoZone) else $error("teach map drives zone"); // RULE10

  property p_air;
    state_reg.mapAct == MAP_AIR && $stable(state_reg.mapAct) && $past(pinIn[2])
      && !$past(pinIn[1]) && !$past(pinIn[0]) |-> cmdPos == `POS_W'(2) && cmdStart;
  endproperty
  a_air: assert property (p_air) else $error("direct command not decoded"); // RULE11
endmodule : parallel_io_pattern_select

//--- pin_sync.sv
/*
  Three-stage synchroniser for the host input pins with an agreement filter.
  Assumes the pins are asynchronous to clk_sys.
*/
`timescale 1ns/100ps
`include "pio_sel_defs.svh"
module pin_sync
  import pio_sel_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [`PIN_W-1:0] pinRaw,
  output logic [`PIN_W-1:0] pinClean
);
  sync_t state_reg;
  sync_t state_next;

  // A change is accepted only once the last two stages agree, which hides a single bad sample.
  always_comb begin
    state_next = state_reg;
    state_next.s1 = pinRaw;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < `PIN_W; i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.q[i] = state_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pinClean = state_reg.q;
endmodule : pin_sync

//--- pio_sel_defs.svh
/*
  Constants for the parallel I/O pattern select block: register offsets, bit
  positions of the host-facing pins and field widths.
  Assumes it is included once by the package and by each design file.
*/
// Operation
// RULE1 - The active I/O map is chosen from a stored map value between 0 and 5.
// RULE2 - Map 0 takes 16 positions, drives one zone output and has no home, servo, reset, jog, write, moving or ready.
// RULE3 - Map 1 takes 16 positions with one zone output and adds home, servo enable, reset, moving and ready.
// RULE4 - Map 2 takes 64 positions and keeps home, reset and moving but drops servo, ready, zones, jog and write.
// RULE5 - Map 3 takes 16 positions with two zone outputs and keeps home, servo, reset and ready but no moving.
// RULE6 - The second zone output uses the lower and upper limits held in stored values 23 and 24.
// RULE7 - Map 4 adds jog motion and writing of the present position to a position number.
// RULE8 - In map 4 the host drives a mode input choosing positioning or teaching operation.
// RULE9 - In map 4 the device drives an output that confirms the mode change has completed.
// RULE10 - Map 4 has no zone output and offers 16 positions with home, servo, reset, jog, write, moving and ready.
// RULE11 - Map 5 has four targets, each with its own command input and completion output, one zone and reset.
// RULE12 - In maps 0, 2 and 5 the configuring party sets stored value 21 to disable servo enable input.
// RULE13 - The host holds the position number stable at least 6 ms before raising start.
// RULE14 - The map value is applied only at reset or reload, and values above five keep the previous map.
`ifndef PIO_SEL_DEFS_SVH
`define PIO_SEL_DEFS_SVH
`define PIN_W 16
`define POS_W 6
`define LIM_W 16
`define MAP_MAX 3'h5
`define REG_MAP 8'h00
`define REG_ZLO 8'h04
`define REG_ZHI 8'h08
`define REG_SVDIS 8'h0c
`define REG_CTRL 8'h10
`define REG_STAT 8'h14
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define IN_START 6
`define IN_PAUSE 7
`define IN_HOME 8
`define IN_SERVO 9
`define IN_RESET 10
`define IN_JOGF 11
`define IN_JOGR 12
`define IN_WRITE 13
`define IN_MODE 14
`define OUT_PEND 6
`define OUT_HEND 7
`define OUT_ZONE1 8
`define OUT_ZONE2 9
`define OUT_MOVE 10
`define OUT_READY 11
`define OUT_ALARM 12
`define OUT_MDONE 13
`endif

//--- pio_sel_pkg.sv
/*
  Types for the parallel I/O pattern select block.
  Assumes the constants header is on the include path.
*/
`include "pio_sel_defs.svh"
package pio_sel_pkg;
  typedef enum logic [2:0] {
    MAP_LEGACY = 3'b000,
    MAP_STD = 3'b001,
    MAP_POS64 = 3'b010,
    MAP_ZONE2 = 3'b011,
    MAP_TEACH = 3'b100,
    MAP_AIR = 3'b101
  } map_t;

  typedef struct packed {
    logic [`PIN_W-1:0] s1;
    logic [`PIN_W-1:0] s2;
    logic [`PIN_W-1:0] s3;
    logic [`PIN_W-1:0] q;
  } sync_t;

  typedef struct packed {
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [2:0] mapStore;
    map_t mapAct;
    logic [`LIM_W-1:0] zoneLo;
    logic [`LIM_W-1:0] zoneHi;
    logic servoDis;
    logic teach;
    logic [`PIN_W-1:0] pioOut;
    logic [`POS_W-1:0] cmdPos;
    logic [9:0] ctl;
  } state_t;
endpackage : pio_sel_pkg

//--- test_parallel_io_pattern_select.sv
/*
  Self-checking bench for the parallel I/O pattern select block.
  Assumes the design files and the host controller model are compiled before it.
*/
`timescale 1ns/100ps
`include "pio_sel_defs.svh"
module test_parallel_io_pattern_select
  import pio_sel_pkg::*;
;
  logic clk_sys, rst_b, go, busy;
  logic [31:0] awaddr, wdata, araddr, rdata, seed, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] pioIn, pioOut, curPos, pinReq, lo, hi, p, e, o;
  logic [5:0] donePos, cmdPos;
  logic posEnd, homeEnd, zone1In, moving, ready, alarmN;
  logic cmdStart, pauseN, homeReq, servoOn, alarmRst, jogFwd, jogRev, writeReq, teachMode;
  int failures, nChecks;

  parallel_io_pattern_select DUT (.clk_sys, .rst_b, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .pioIn, .pioOut, .curPos, .donePos, .posEnd, .homeEnd, .zone1In,
    .moving, .ready, .alarmN, .cmdPos, .cmdStart, .pauseN, .homeReq, .servoOn, .alarmRst,
    .jogFwd, .jogRev, .writeReq, .teachMode);
  // The 6 ms hold is shortened so that a full sweep of all maps stays brief.
  host_plc_model #(.HOLD_CYC(8)) plc (.clk_sys, .rst_b, .pinReq, .go, .pioIn, .busy);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  function automatic logic [15:0] exp_ctl(input logic [2:0] m, input logic [15:0] q);
    logic [15:0] x;
    logic t;
    x = 16'h0000;
    t = (m == 3'h4) & q[14];
    x[5:0] = (m == 3'h2) ? q[5:0] : {2'h0, q[3:0]};
    if (m == 3'h5) begin
      x[5:0] = q[0] ? 6'h00 : q[1] ? 6'h01 : q[2] ? 6'h02 : 6'h03;
    end
    x[6] = (m == 3'h5) ? |q[3:0] : q[6];
    x[7] = q[8] & (m != 3'h0) & (m != 3'h5);
    x[8] = q[10] & (m != 3'h0);
    x[9] = t & q[11];
    x[10] = t & q[12];
    x[11] = t & q[13];
    x[12] = t;
    // Where the servo enable pin is absent the bench has set the disable bit, so servo stays on.
    x[13] = (m == 3'h1 || m == 3'h3 || m == 3'h4) ? q[9] : 1'b1;
    x[14] = q[7];
    return x;
  endfunction : exp_ctl

  function automatic logic [15:0] exp_pio(input logic [2:0] m);
    logic [15:0] x;
    x = 16'h0000;
    if (m == 3'h5 && posEnd && donePos < 6'h04) begin
      x[donePos[1:0]] = 1'b1;
    end
    if (m != 3'h5) begin
      x[5:0] = donePos;
    end
    x[6] = posEnd;
    x[7] = homeEnd;
    x[12] = alarmN;
    x[8] = zone1In & (m != 3'h2) & (m != 3'h4);
    x[9] = (m == 3'h3) & homeEnd & (curPos >= lo) & (curPos <= hi);
    x[10] = moving & (m == 3'h1 || m == 3'h2 || m == 3'h4);
    x[11] = ready & (m == 3'h1 || m == 3'h3 || m == 3'h4);
    x[13] = (m == 3'h4);
    return x;
  endfunction : exp_pio

  task automatic report_and_stop();
    if (failures == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nChecks++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask : check

  task automatic give_up(input int n);
    if (n >= 64) begin
      failures++;
      report_and_stop();
    end
  endtask : give_up

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    r = bresp;
    bready <= 1'b0;
    give_up(n);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    give_up(n);
  endtask : axi_rd

  task automatic apply_pins(input logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    pinReq <= q;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (busy && n < 64);
    give_up(n);
    repeat (8) @(posedge clk_sys);
  endtask : apply_pins

  initial begin
    rst_b = 1'b0;
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    {pinReq, go, curPos, donePos, posEnd, homeEnd, zone1In, moving, ready, alarmN} = '0;
    seed = 32'h0000004f;
    failures = 0;
    nChecks = 0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    axi_rd(32'(`REG_STAT), rd, rsp);
    check(32'(rd[3:1]), 32'h0);
    axi_rd(32'h00000040, rd, rsp);
    check({rd[29:0], rsp}, 32'(`RESP_SLVERR));
    axi_wr(32'h00000044, 32'h00000001, rsp);
    check(32'(rsp), 32'(`RESP_SLVERR));
    seed = xs(seed);
    lo = {1'b0, seed[14:0]} | 16'h0010;
    hi = lo + 16'h0100;
    axi_wr(32'(`REG_ZLO), 32'(lo), rsp);
    axi_wr(32'(`REG_ZHI), 32'(hi), rsp);
    axi_rd(32'(`REG_ZLO), rd, rsp);
    check(32'(rd[15:0]), 32'(lo));
    axi_rd(32'(`REG_ZHI), rd, rsp);
    check(32'(rd[15:0]), 32'(hi));
    axi_wr(32'(`REG_SVDIS), 32'h00000001, rsp);
    for (int m = 0; m < 6; m++) begin
      axi_wr(32'(`REG_MAP), 32'(m), rsp);
      axi_wr(32'(`REG_CTRL), 32'h00000001, rsp);
      axi_rd(32'(`REG_STAT), rd, rsp);
      check(32'(rd[3:1]), 32'(m));
      check(32'(rsp), 32'(`RESP_OKAY));
      // Teach mode starts clear and follows the mode pin only while the core is stopped.
      check(32'(rd[4]), (m == 4) ? 32'(p[14] & ~moving) : 32'h0);
      for (int i = 0; i < 6; i++) begin
        seed = xs(seed);
        p = seed[15:0] & 16'h7fff;
        if (m == 5 && p[3:0] == 4'h0) p[3] = 1'b1;
        curPos <= (i == 0) ? lo : (i == 1) ? hi : (i == 2) ? lo - 16'h0001 : hi + 16'h0001;
        donePos <= seed[21:16];
        {posEnd, homeEnd, zone1In, ready, alarmN} <= {seed[22], seed[23] | (i < 3), seed[27:25]};
        moving <= seed[28] & (m != 4);
        apply_pins(p);
        e = exp_ctl(m[2:0], p);
        o = {1'b0, pauseN, servoOn, teachMode, writeReq, jogRev, jogFwd, alarmRst, homeReq,
          cmdStart, cmdPos};
        check(32'(o), 32'(e));
        check(32'(pioOut), 32'(exp_pio(m[2:0])));
      end
    end
    axi_wr(32'(`REG_MAP), 32'h00000006, rsp);
    axi_wr(32'(`REG_CTRL), 32'h00000001, rsp);
    axi_wr(32'(`REG_MAP), 32'h00000001, rsp);
    axi_rd(32'(`REG_STAT), rd, rsp);
    check(32'(rd[3:1]), 32'h5);
    report_and_stop();
  end
endmodule : test_parallel_io_pattern_select
